// File: hw/cpsc_map.svh
// register offsets, bit positions and reset values of the protection control block
// assumes inclusion by bare name from the design files
`ifndef CPSC_MAP_SVH
`define CPSC_MAP_SVH

`define CPSC_CFG_OFS       8'hb8
`define CPSC_CTL_OFS       8'hc0
`define CPSC_STS_OFS       8'hc4

`define CPSC_CFG_RST       8'h00
`define CPSC_CTL_RST       8'h00
`define CPSC_STS_RST       8'h00

`define CPSC_CTL_AUTH_EN   0
`define CPSC_CTL_AUTH_DIS  1
`define CPSC_CTL_ENC_EN    2
`define CPSC_CTL_ENC_DIS   3
`define CPSC_CTL_KEY_ACC   4
`define CPSC_CTL_LIST_ACC  5

`define CPSC_STS_AUTHENTICATED_FLAG    0
`define CPSC_STS_KEY_RDY   1
`define CPSC_STS_LIST_RDY  2
`define CPSC_STS_RX_DET    3
`define CPSC_STS_HOT_PLUG  4
`define CPSC_STS_RX_LOCK   5
`define CPSC_STS_RX_INT    6
`define CPSC_STS_CHAN_ERR  7

`define CPSC_CFG_MODE_LSB  3
`define CPSC_CFG_MODE_MSB  4
`define CPSC_CFG_RPTR      5

`endif

// File: hw/cpsc_pkg.sv
// types shared by the protection control block and its bus slave
// assumes nothing beyond a SystemVerilog compiler
package cpsc_pkg;

  typedef enum logic [1:0] {
    CPSC_MODE_AUTHENTICATED_FLAG = 2'b00,
    CPSC_MODE_REG    = 2'b01,
    CPSC_MODE_ALWAYS = 2'b10,
    CPSC_MODE_INBAND = 2'b11
  } cpsc_mode_e;

  typedef enum logic [1:0] {
    CPSC_VID_PLAIN  = 2'b00,
    CPSC_VID_CIPHER = 2'b01,
    CPSC_VID_BLUE   = 2'b10
  } cpsc_video_e;

  typedef enum logic [1:0] {
    CPSC_BUS_IDLE    = 2'b00,
    CPSC_BUS_WRITE   = 2'b01,
    CPSC_BUS_RD_WAIT = 2'b10,
    CPSC_BUS_RD_DONE = 2'b11
  } cpsc_bus_e;

  typedef struct packed {
    cpsc_bus_e   state;
    logic [7:0]  addr;
    logic [31:0] hrdata;
  } cpsc_bus_s;

  typedef struct packed {
    logic        auth_en;
    logic        authenticated_flag;
    logic        key_ready;
    logic        list_ready;
    logic        chan_err;
    logic        hot_plug;
    logic        key_acc;
    logic        enc_en;
    logic        enc_off;
    cpsc_mode_e  mode;
    logic        repeater;
    logic        start_p;
    logic        stop_p;
    logic        list_acc_p;
    cpsc_video_e video;
  } cpsc_core_s;

endpackage

// File: hw/cpsc_ahb_slave.sv
// ahb-lite single-slave front end: word registers, zero-wait writes, one-wait reads
// assumes hready is this slave's own hreadyout and one clock domain
`timescale 1ns/1ns
`default_nettype none

module cpsc_ahb_slave (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [7:0]       reg_addr,
  output logic             reg_wr,
  output logic [31:0]      reg_wdata,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);

  cpsc_pkg::cpsc_bus_s s_r;
  cpsc_pkg::cpsc_bus_s s_nxt;
  logic                take;

  // only whole-word single transfers are expected; hsize is not decoded
  assign take      = hsel & htrans[1] & hready;
  assign hreadyout = (s_r.state != cpsc_pkg::CPSC_BUS_RD_WAIT);
  assign hrdata    = s_r.hrdata;
  assign hresp     = 1'b0;
  assign reg_addr  = s_r.addr;
  assign reg_wdata = hwdata;
  assign reg_wr    = (s_r.state == cpsc_pkg::CPSC_BUS_WRITE);
  assign reg_rd    = (s_r.state == cpsc_pkg::CPSC_BUS_RD_DONE);

  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      cpsc_pkg::CPSC_BUS_RD_WAIT: begin
        s_nxt.hrdata = reg_rdata;
        s_nxt.state  = cpsc_pkg::CPSC_BUS_RD_DONE;
      end
      default: begin
        if (take) begin
          s_nxt.addr  = haddr[7:0];
          s_nxt.state = hwrite ? cpsc_pkg::CPSC_BUS_WRITE : cpsc_pkg::CPSC_BUS_RD_WAIT;
        end else begin
          s_nxt.state = cpsc_pkg::CPSC_BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// File: hw/cpsc_ctrl.sv
// protection control and status registers with video encryption policy
// assumes an authentication engine that reports events as one-cycle pulses
// and receiver link levels synchronous to clk
//
// Functional notes
// RULE1: host sets key accepted only after checking receiver key against revocation.
// RULE2: key accepted clears when key ready rises; writing zero does nothing.
// RULE3: encryption disable write sends plain video, keeps auth state, self-clears.
// RULE4: encryption enabled: encrypted when authenticated, blue screen otherwise.
// RULE5: encryption enable clear: incoming video passes without encryption.
// RULE6: in always-encrypt mode encryption enable is read-only and reads one.
// RULE7: host should keep encryption enabled for protected content.
// RULE8: authentication disable write turns authentication off and self-clears.
// RULE9: authentication enable write one starts or restarts; zero does nothing.
// RULE10: authentication enable reads back the live enabled state.
// RULE11: channel error flag set on channel error, cleared by status read.
// RULE12: receiver interrupt bit mirrors the active-low remote interrupt.
// RULE13: receiver lock bit shows downstream receiver lock.
// RULE14: hot plug flag set on new downstream receiver, cleared by status read.
// RULE15: receiver detected bit shows a receiver found on the link.
// RULE16: key list ready set when list stored; authentication halts until list accepted.
// RULE17: key list ready clears when host sets list accepted.
// RULE18: key ready set when key stored; non-repeater halts until key accepted.
// RULE19: key ready clears when host sets key accepted.
// RULE20: authenticated set when authentication completes successfully.
// RULE21: authenticated clears on loss of authentication or host restart.
// RULE22: all status bits reset to zero; the live detect, lock and interrupt bits follow their inputs instead.
// RULE23: two-bit mode: authenticated, register, always, per-frame in-band.
// RULE24: host sets self-clearing list accepted after checking the key list.
// RULE25: clear-on-read only on completed status read; same-cycle events stay set.
`timescale 1ns/1ns
`default_nettype none
`include "cpsc_map.svh"

module cpsc_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rx_detect,
  input  wire logic        rx_lock,
  input  wire logic        remote_interrupt_input_n,
  input  wire logic        chan_err_evt,
  input  wire logic        hot_plug_evt,
  input  wire logic        key_ready_evt,
  input  wire logic        list_ready_evt,
  input  wire logic        auth_done_evt,
  input  wire logic        auth_lost_evt,
  input  wire logic        frame_encrypt_req,
  output logic             auth_enabled,
  output logic             auth_start,
  output logic             auth_stop,
  output logic             receiver_key_accepted,
  output logic             key_list_accepted,
  output logic             auth_hold,
  output logic [1:0]       video_mode
);

  logic [7:0]           reg_addr;
  logic                 reg_wr;
  logic [31:0]          reg_wdata;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  cpsc_pkg::cpsc_core_s c_r;
  cpsc_pkg::cpsc_core_s c_nxt;
  logic [7:0]           sts_rd;
  logic [7:0]           ctl_rd;
  logic [7:0]           cfg_rd;
  logic                 wr_ctl;
  logic                 wr_cfg;
  logic                 rd_sts;
  logic                 want_enc;

  cpsc_ahb_slave u_cpsc_ahb_slave (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_wdata (reg_wdata),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  assign wr_ctl = reg_wr & (reg_addr == `CPSC_CTL_OFS);
  assign wr_cfg = reg_wr & (reg_addr == `CPSC_CFG_OFS);
  assign rd_sts = reg_rd & (reg_addr == `CPSC_STS_OFS);               // [RULE25]

  // status image, live link levels mixed with sticky flags
  always_comb begin
    sts_rd                     = `CPSC_STS_RST;
    sts_rd[`CPSC_STS_AUTHENTICATED_FLAG]   = c_r.authenticated_flag;
    sts_rd[`CPSC_STS_KEY_RDY]  = c_r.key_ready;
    sts_rd[`CPSC_STS_LIST_RDY] = c_r.list_ready;
    sts_rd[`CPSC_STS_RX_DET]   = rx_detect;                             // [RULE15]
    sts_rd[`CPSC_STS_HOT_PLUG] = c_r.hot_plug;
    sts_rd[`CPSC_STS_RX_LOCK]  = rx_lock;                               // [RULE13]
    sts_rd[`CPSC_STS_RX_INT]   = remote_interrupt_input_n;              // [RULE12]
    sts_rd[`CPSC_STS_CHAN_ERR] = c_r.chan_err;
  end

  // self-clearing bits read as zero
  always_comb begin
    ctl_rd                     = `CPSC_CTL_RST;
    ctl_rd[`CPSC_CTL_AUTH_EN]  = c_r.auth_en;                           // [RULE10]
    ctl_rd[`CPSC_CTL_ENC_EN]   = c_r.enc_en | (c_r.mode == cpsc_pkg::CPSC_MODE_ALWAYS); // [RULE6]
    ctl_rd[`CPSC_CTL_KEY_ACC]  = c_r.key_acc;
  end

  always_comb begin
    cfg_rd = `CPSC_CFG_RST;
    cfg_rd[`CPSC_CFG_MODE_MSB:`CPSC_CFG_MODE_LSB] = c_r.mode;
    cfg_rd[`CPSC_CFG_RPTR] = c_r.repeater;
  end

  always_comb begin
    case (reg_addr)
      `CPSC_STS_OFS: reg_rdata = {24'h000000, sts_rd};
      `CPSC_CTL_OFS: reg_rdata = {24'h000000, ctl_rd};
      `CPSC_CFG_OFS: reg_rdata = {24'h000000, cfg_rd};
      default:       reg_rdata = 32'h00000000;
    endcase
  end

  // policy: whether the current frame asks for encryption
  always_comb begin
    case (c_r.mode)                                                     // [RULE23]
      cpsc_pkg::CPSC_MODE_AUTHENTICATED_FLAG: want_enc = c_r.authenticated_flag;
      cpsc_pkg::CPSC_MODE_REG:    want_enc = c_r.enc_en;
      cpsc_pkg::CPSC_MODE_ALWAYS: want_enc = 1'b1;
      cpsc_pkg::CPSC_MODE_INBAND: want_enc = frame_encrypt_req;
      default:                    want_enc = 1'b0;
    endcase
  end

  always_comb begin
    c_nxt            = c_r;
    c_nxt.start_p    = 1'b0;
    c_nxt.stop_p     = 1'b0;
    c_nxt.list_acc_p = 1'b0;

    // configuration register
    if (wr_cfg) begin
      c_nxt.mode     = cpsc_pkg::cpsc_mode_e'(reg_wdata[`CPSC_CFG_MODE_MSB:`CPSC_CFG_MODE_LSB]); // [RULE23]
      c_nxt.repeater = reg_wdata[`CPSC_CFG_RPTR];
    end

    // clear-on-read flags; events below override the clear
    if (rd_sts) begin
      c_nxt.chan_err = 1'b0;                                            // [RULE11]
      c_nxt.hot_plug = 1'b0;                                            // [RULE14]
    end

    // control writes
    if (wr_ctl) begin
      if (reg_wdata[`CPSC_CTL_AUTH_EN]) begin                           // [RULE9]
        c_nxt.auth_en = 1'b1;
        c_nxt.start_p = 1'b1;
        c_nxt.authenticated_flag  = 1'b0;                                           // [RULE21]
        c_nxt.enc_off = 1'b0;
      end
      if (reg_wdata[`CPSC_CTL_AUTH_DIS]) begin                          // [RULE8]
        c_nxt.auth_en = 1'b0;
        c_nxt.start_p = 1'b0;
        c_nxt.stop_p  = 1'b1;
        c_nxt.authenticated_flag  = 1'b0;
      end
      if (c_r.mode != cpsc_pkg::CPSC_MODE_ALWAYS) begin                 // [RULE6]
        c_nxt.enc_en = reg_wdata[`CPSC_CTL_ENC_EN];
      end
      if (reg_wdata[`CPSC_CTL_ENC_EN]) begin
        c_nxt.enc_off = 1'b0;
      end
      if (reg_wdata[`CPSC_CTL_ENC_DIS]) begin                           // [RULE3]
        c_nxt.enc_off = 1'b1;
      end
      if (reg_wdata[`CPSC_CTL_KEY_ACC]) begin                           // [RULE2]
        c_nxt.key_acc   = 1'b1;
        c_nxt.key_ready = 1'b0;                                         // [RULE19]
      end
      if (reg_wdata[`CPSC_CTL_LIST_ACC]) begin                          // [RULE24]
        c_nxt.list_acc_p = 1'b1;
        c_nxt.list_ready = 1'b0;                                        // [RULE17]
      end
    end

    // hardware events; a set wins over any clear in the same cycle
    if (chan_err_evt) begin
      c_nxt.chan_err = 1'b1;                                            // [RULE11] [RULE25]
    end
    if (hot_plug_evt) begin
      c_nxt.hot_plug = 1'b1;                                            // [RULE14] [RULE25]
    end
    if (c_r.auth_en) begin
      if (key_ready_evt) begin
        c_nxt.key_ready = 1'b1;                                         // [RULE18]
        // a fresh key withdraws an earlier acceptance unless rewritten now
        if (!c_r.key_ready && !(wr_ctl && reg_wdata[`CPSC_CTL_KEY_ACC])) begin
          c_nxt.key_acc = 1'b0;                                         // [RULE2]
        end
      end
      if (list_ready_evt) begin
        c_nxt.list_ready = 1'b1;                                        // [RULE16]
      end
      if (auth_lost_evt) begin
        c_nxt.authenticated_flag = 1'b0;                                            // [RULE21]
      end
      if (auth_done_evt) begin
        c_nxt.authenticated_flag = 1'b1;                                            // [RULE20]
      end
    end

    // video path selection
    if (c_r.enc_off || !want_enc) begin                                 // [RULE3] [RULE5]
      c_nxt.video = cpsc_pkg::CPSC_VID_PLAIN;
    end else if (c_r.authenticated_flag) begin                                      // [RULE4]
      c_nxt.video = cpsc_pkg::CPSC_VID_CIPHER;
    end else begin
      c_nxt.video = cpsc_pkg::CPSC_VID_BLUE;                            // [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_r <= '0;                                                        // [RULE22]
    end else begin
      c_r <= c_nxt;
    end
  end

  assign auth_enabled          = c_r.auth_en;
  assign auth_start            = c_r.start_p;
  assign auth_stop             = c_r.stop_p;
  assign receiver_key_accepted = c_r.key_acc;                           // [RULE1]
  assign key_list_accepted     = c_r.list_acc_p;
  // engine waits on an unaccepted key (non-repeater) or an unaccepted list
  assign auth_hold             = (c_r.key_ready & ~c_r.repeater) | c_r.list_ready; // [RULE16] [RULE18]
  assign video_mode            = c_r.video;

endmodule

`default_nettype wire

// File: tb/cpsc_ctrl_monitor.sv
// port assertions for the protection control block
// assumes binding to cpsc_ctrl, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
`include "cpsc_map.svh"
module cpsc_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        rx_detect,
  input wire logic        rx_lock,
  input wire logic        remote_interrupt_input_n,
  input wire logic        list_ready_evt,
  input wire logic        auth_done_evt,
  input wire logic        auth_lost_evt,
  input wire logic        auth_enabled,
  input wire logic        auth_start,
  input wire logic        auth_stop,
  input wire logic        receiver_key_accepted,
  input wire logic        key_list_accepted,
  input wire logic        auth_hold,
  input wire logic [1:0]  video_mode
);
  logic tk;
  logic wr_q;
  logic rd_q;
  assign tk = hsel && htrans[1] && hready;
  // data-phase markers of control writes and status reads
  always_ff @(posedge clk) begin
    wr_q <= !rst && tk && hwrite && haddr[7:0] == `CPSC_CTL_OFS;
    rd_q <= !rst && tk && !hwrite && haddr[7:0] == `CPSC_STS_OFS;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_stop;
    wr_q && hwdata[1] |=> auth_stop && !auth_enabled;
  endproperty
  a_stop: assert property (p_stop) else $error("stop write ignored");
  property p_start;
    wr_q && hwdata[0] && !hwdata[1] |=> auth_start && auth_enabled;
  endproperty
  a_start: assert property (p_start) else $error("start write ignored");
  property p_key_acc;
    !receiver_key_accepted && !(wr_q && hwdata[4]) |=> !receiver_key_accepted;
  endproperty
  a_key_acc: assert property (p_key_acc) else $error("key accepted set unasked");
  property p_list_acc;
    wr_q && hwdata[5] |=> key_list_accepted ##1 !key_list_accepted;
  endproperty
  a_list_acc: assert property (p_list_acc) else $error("list accepted pulse bad");
  property p_enc_off;
    wr_q && hwdata[3] && !hwdata[2] && !hwdata[0] |=> ##1 video_mode == cpsc_pkg::CPSC_VID_PLAIN;
  endproperty
  a_enc_off: assert property (p_enc_off) else $error("video not plain");
  property p_lost;
    auth_lost_evt && !auth_done_evt |=> ##1 video_mode != cpsc_pkg::CPSC_VID_CIPHER;
  endproperty
  a_lost: assert property (p_lost) else $error("cipher after loss");
  property p_mirror;
    rd_q ##1 hreadyout |-> hrdata[6] == $past(remote_interrupt_input_n) && hrdata[5] == $past(rx_lock)
      && hrdata[3] == $past(rx_detect);
  endproperty
  a_mirror: assert property (p_mirror) else $error("status levels wrong");
  property p_hold;
    auth_enabled && list_ready_evt && !wr_q |=> auth_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold on list");
  c_start: cover property (wr_q && hwdata[0]);
  c_read: cover property (rd_q);
  c_done: cover property (auth_done_evt && auth_enabled);
endmodule
bind cpsc_ctrl cpsc_ctrl_monitor u_cpsc_ctrl_monitor (.*);
`default_nettype wire

// File: tb/cpsc_rx_model.sv
// far side: receiver levels and authentication engine event pulses
// assumes the bench requests each event for one cycle
`timescale 1ns/1ns
`default_nettype none
module cpsc_rx_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [8:0] cmd,
  output logic [8:0]      pins
);
  logic [8:3] asked_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pins    <= 9'h004; // interrupt line idles high
      asked_q <= 6'h00;
    end else begin
      // events pulse once per request however long it is held
      pins    <= {cmd[8:3] & ~asked_q, cmd[2:0]};
      asked_q <= cmd[8:3];
    end
  end
endmodule
`default_nettype wire

// File: tb/cpsc_ctrl_tb.sv
// self-checking bench for the protection control block
// assumes cpsc_ctrl, its monitor and the far-side model
`timescale 1ns/1ns
`default_nettype none
`include "cpsc_map.svh"
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module cpsc_ctrl_tb;
  logic        clk;
  logic        rst;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        frame_req;
  logic [8:0]  cmd;
  logic [8:0]  pins;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        auth_hold;
  logic [1:0]  video_mode;
  logic [31:0] q;
  logic [2:0]  lv;
  logic [1:0]  e;
  int          miscompares;
  int          checked;

  cpsc_rx_model u_cpsc_rx_model (.clk(clk), .rst(rst), .cmd(cmd), .pins(pins));
  cpsc_ctrl u_cpsc_ctrl (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rx_detect(pins[0]), .rx_lock(pins[1]),
    .remote_interrupt_input_n(pins[2]), .chan_err_evt(pins[3]), .hot_plug_evt(pins[4]),
    .key_ready_evt(pins[5]), .list_ready_evt(pins[6]), .auth_done_evt(pins[7]),
    .auth_lost_evt(pins[8]), .frame_encrypt_req(frame_req), .auth_enabled(), .auth_start(),
    .auth_stop(), .receiver_key_accepted(), .key_list_accepted(), .auth_hold(auth_hold),
    .video_mode(video_mode));

  function automatic logic [7:0] lvl(input logic [2:0] v);
    return {1'b0, v[2], v[1], 1'b0, v[0], 3'b000};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic r;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = (hreadyout === 1'b1);
      @(posedge clk);
    end
    htrans <= 2'b00;
    hwdata <= d;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = (hreadyout === 1'b1);
      q = hrdata;
      @(posedge clk);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 32'h0);
    `CHK(q, {24'h0, x})
  endtask

  task automatic ev(input logic [8:0] m);
    cmd <= cmd | m;
    @(posedge clk);
    cmd <= cmd & ~m;
    repeat (3) @(posedge clk);
  endtask

  task automatic vid(input logic [1:0] x);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(video_mode, x)
    @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    frame_req = 1'b0;
    cmd = 9'h004;
    miscompares = 0;
    checked = 0;
    q = $urandom(21112);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(`CPSC_STS_OFS, 8'h40);
    rdc(`CPSC_CTL_OFS, 8'h00);
    rdc(8'h10, 8'h00);
    for (int i = 0; i < 16; i++) begin
      lv = 3'($urandom);
      e = 2'($urandom);
      cmd <= {6'h0, lv};
      @(posedge clk);
      ev({4'h0, e[1], e[0], 3'b000});
      rdc(`CPSC_STS_OFS, lvl(lv) | {e[0], 2'b00, e[1], 4'h0});
      rdc(`CPSC_STS_OFS, lvl(lv));
    end
    cmd <= 9'h007;
    bus(1'b1, `CPSC_CFG_OFS, 32'h08);
    bus(1'b1, `CPSC_CTL_OFS, 32'h01);
    rdc(`CPSC_CTL_OFS, 8'h01);
    bus(1'b1, `CPSC_CTL_OFS, 32'h00);
    rdc(`CPSC_CTL_OFS, 8'h01);
    ev(9'h020);
    `CHK(auth_hold, 1'b1)
    rdc(`CPSC_STS_OFS, 8'h6a);
    bus(1'b1, `CPSC_CTL_OFS, 32'h10); // key checked first
    rdc(`CPSC_STS_OFS, 8'h68);
    rdc(`CPSC_CTL_OFS, 8'h11);
    ev(9'h020);
    rdc(`CPSC_CTL_OFS, 8'h01);
    bus(1'b1, `CPSC_CTL_OFS, 32'h10);
    ev(9'h040);
    rdc(`CPSC_STS_OFS, 8'h6c);
    bus(1'b1, `CPSC_CTL_OFS, 32'h20); // list checked first
    rdc(`CPSC_STS_OFS, 8'h68);
    ev(9'h080);
    rdc(`CPSC_STS_OFS, 8'h69);
    bus(1'b1, `CPSC_CTL_OFS, 32'h04);
    vid(2'b01);
    bus(1'b1, `CPSC_CFG_OFS, 32'h10);
    bus(1'b1, `CPSC_CTL_OFS, 32'h08);
    vid(2'b00);
    rdc(`CPSC_STS_OFS, 8'h69);
    rdc(`CPSC_CTL_OFS, 8'h15);
    bus(1'b1, `CPSC_CTL_OFS, 32'h04);
    vid(2'b01);
    bus(1'b1, `CPSC_CFG_OFS, 32'h18);
    vid(2'b00);
    frame_req <= 1'b1;
    vid(2'b01);
    bus(1'b1, `CPSC_CFG_OFS, 32'h00);
    vid(2'b01);
    bus(1'b1, `CPSC_CTL_OFS, 32'h01);
    rdc(`CPSC_STS_OFS, 8'h68);
    bus(1'b1, `CPSC_CFG_OFS, 32'h08);
    bus(1'b1, `CPSC_CTL_OFS, 32'h04);
    vid(2'b10);
    bus(1'b1, `CPSC_CTL_OFS, 32'h00);
    vid(2'b00);
    bus(1'b1, `CPSC_CFG_OFS, 32'h10);
    rdc(`CPSC_CTL_OFS, 8'h15);
    vid(2'b10);
    ev(9'h080);
    ev(9'h100);
    rdc(`CPSC_STS_OFS, 8'h68);
    bus(1'b1, `CPSC_CFG_OFS, 32'h20);
    ev(9'h020);
    `CHK(auth_hold, 1'b0)
    rdc(`CPSC_STS_OFS, 8'h6a);
    bus(1'b1, `CPSC_CTL_OFS, 32'h02);
    bus(1'b0, `CPSC_CTL_OFS, 32'h0);
    `CHK(q[0], 1'b0)
    print_verdict();
  end
endmodule
`default_nettype wire
